// [logic/bwe_pkg.sv]
// Constants, carrier types, state encoding and CRC helpers for the block write engine
`default_nettype none
package bwe_pkg;
	// Command and parameter decoding
	localparam logic [7:0]  CMD_WRITE_BLOCK = 8'h55;
	localparam logic [4:0]  LAST_BLOCK      = 5'h1e;
	localparam int          BLK_IDX_MSB     = 4;
	// Memory geometry
	localparam int          NUM_BLOCKS      = 31;
	localparam int          BLOCK_BYTES     = 8;
	localparam int          USER_BYTES      = 248;
	localparam int          ADMIN_BYTES     = 32;
	localparam int          PROT_BITS       = 32;
	localparam logic [3:0]  MAX_WRITES      = 4'h8;
	localparam logic [7:0]  UNMAPPED_READ   = 8'hff;
	// Status byte codes
	localparam logic [3:0]  CS_OK_NIBBLE    = 4'ha;
	localparam logic [7:0]  CS_PROTECTED    = 8'h55;
	localparam logic [7:0]  CS_EXHAUSTED    = 8'h33;
	localparam logic [7:0]  CS_FAULT        = 8'hee;
	// CRC generators, both shifted least significant bit first
	localparam logic [7:0]  CRC8_POLY_REV   = 8'h8c;
	localparam logic [7:0]  CRC8_INIT       = 8'h00;
	localparam logic [15:0] CRC16_POLY_REV  = 16'ha001;
	localparam logic [15:0] CRC16_INIT      = 16'h0000;
	// Node identifier layout
	localparam int          ID_DATA_BITS    = 56;
	localparam logic [5:0]  ID_DATA_LAST    = 6'h38;
	// Programming time
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          PROG_TIME_MS    = 20;
	localparam int          PROG_CYCLES     = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} bwe_byte_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] block;
	} bwe_prot_req_t;

	typedef enum logic [2:0] {
		S_IDLE, S_PARAM, S_DATA, S_RELEASE, S_PROG, S_TX, S_HALT
	} bwe_state_t;

	// One bit into the identifier CRC
	function automatic logic [7:0] bwe_crc8_bit(input logic [7:0] crc, input logic b);
		logic fb;
		fb = crc[0] ^ b;
		bwe_crc8_bit = {1'b0, crc[7:1]} ^ (fb ? CRC8_POLY_REV : 8'h00);
	endfunction : bwe_crc8_bit

	// One byte into the CRC-16 generator
	function automatic logic [15:0] bwe_crc16(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			c = {1'b0, c[15:1]} ^ (c[0] ? CRC16_POLY_REV : 16'h0000);
		bwe_crc16 = c;
	endfunction : bwe_crc16
endpackage : bwe_pkg
`default_nettype wire

// [logic/bwe_block_write_engine.sv]
// Command-level block write engine of a single-contact serial memory
// What this block does
// - Holds a 64-bit node identifier: family code, 48-bit serial, 8-bit CRC.
// - Identifier CRC uses shift-register generator for x^8 + x^5 + x^4 + 1.
// - Identifier CRC starts at zero, shifts family then serial, LSB first.
// - User memory is 31 blocks of 8 bytes, blocks 00h to 1Eh.
// - A block's write protection, once set, is never cleared.
// - Each command takes one parameter byte; a valid one earns a CRC-16.
// - Each block may be programmed at most 8 times; remaining count tracked.
// - Multi-byte values go least significant byte and bit first.
// - Every CRC-16 is transmitted bitwise inverted.
// - Command 55h writes a whole block via the buffer, decrementing its count.
// - One write flow continues to the next adjacent block after each successful write, up to the last; a refusal or fault halts it.
// - A CRC follows the parameter byte and another follows the 8 data bytes.
// - After a good data CRC a release byte starts programming; status follows.
// - Status is xAh with remaining count, 55h protected, 33h exhausted, EEh fault.
// - Protected or exhausted blocks are not programmed; matching status is sent.
// - First CRC covers command then parameter, in a cleared generator.
// - Later CRCs cover the 8 data bytes alone, in a cleared generator.
// - Parameter bits 4:0 pick the block; 1Fh is an invalid parameter.
// - Keeps 8-byte write-only buffer, 32 admin bytes, 4 protection bytes.
// - Programming time starts as soon as the release byte is received.
`timescale 1ns/1ps
`default_nettype none
module bwe_block_write_engine
	import bwe_pkg::*;
#(
	parameter int          P_PROG_CYCLES = PROG_CYCLES,
	parameter logic [7:0]  P_FAMILY_CODE = 8'h5c,          // Arbitrary value
	parameter logic [47:0] P_SERIAL      = 48'h0123_4567_89ab  // Arbitrary value
) (
	// Clock and reset
	input  wire logic          i_core_clk,
	input  wire logic          i_resetn,
	// Byte layer below: received bytes, bus reset, transmit completion
	input  wire bwe_byte_t     i_rx_byte,
	input  wire logic          i_bus_reset,
	input  wire logic          i_tx_done,
	output var  bwe_byte_t     o_tx_byte,
	// Side inputs from the array and the protection command handler
	input  wire logic          i_prog_fault,
	input  wire bwe_prot_req_t i_prot_req,
	// Internal read port of user memory
	input  wire logic [7:0]    i_rd_addr,
	output logic [7:0]         o_rd_data,
	// Status
	output logic [63:0]        o_node_identifier,
	output logic               o_id_ready,
	output logic               o_busy
);

	// Control state
	bwe_state_t  state_r, state_nxt, ret_r, ret_nxt;
	logic [4:0]  blk_r, blk_nxt;
	logic [2:0]  bcnt_r, bcnt_nxt;
	logic [15:0] crc_r, crc_nxt;
	logic [15:0] tx_sh_r, tx_sh_nxt;
	logic        tx_last_r, tx_last_nxt;
	logic        tx_wait_r;
	logic [22:0] timer_r, timer_nxt;
	logic        wb_we, prog_we;

	// Storage: write buffer, admin counts, protection bits, user array
	logic [7:0]  wbuf_r [BLOCK_BYTES];
	logic [7:0]  adm_r  [ADMIN_BYTES];
	logic [PROT_BITS-1:0] prot_r;
	logic [7:0]  mem_r  [USER_BYTES];

	// Identifier generation
	logic [5:0]  id_cnt_r;
	logic [7:0]  crc8_r;
	wire  [55:0] id_data = {P_SERIAL, P_FAMILY_CODE};

	// Decoding of the current byte and block
	wire         rx        = i_rx_byte.valid;
	wire  [7:0]  rd        = i_rx_byte.data;
	wire  [15:0] crc_upd   = bwe_crc16(crc_r, rd);
	wire         idx_ok    = rd[BLK_IDX_MSB:0] <= LAST_BLOCK;
	wire         blk_prot  = prot_r[blk_r];
	wire  [3:0]  blk_cnt   = adm_r[blk_r][3:0];
	wire         cnt_zero  = blk_cnt == 4'h0;
	wire  [3:0]  cnt_left  = blk_cnt - 4'h1;
	wire         blk_last  = blk_r == LAST_BLOCK;
	wire         timer_end = timer_r == 23'h000000;
	wire  [22:0] timer_ld  = 23'(P_PROG_CYCLES - 1);

	// Command flow; a bus reset overrides the next state and clears the generator
	always_comb
	begin
		state_nxt   = state_r;
		ret_nxt     = ret_r;
		blk_nxt     = blk_r;
		bcnt_nxt    = bcnt_r;
		crc_nxt     = crc_r;
		tx_sh_nxt   = tx_sh_r;
		tx_last_nxt = tx_last_r;
		timer_nxt   = timer_r;
		wb_we       = 1'b0;
		prog_we     = 1'b0;
		unique case (state_r)
			S_IDLE:
				if (rx)
				begin
					crc_nxt   = crc_upd;
					state_nxt = (rd == CMD_WRITE_BLOCK) ? S_PARAM : S_HALT;
				end
			S_PARAM:
				if (rx && idx_ok)
				begin
					blk_nxt     = rd[BLK_IDX_MSB:0];
					tx_sh_nxt   = ~crc_upd;
					tx_last_nxt = 1'b0;
					ret_nxt     = S_DATA;
					state_nxt   = S_TX;
					crc_nxt     = CRC16_INIT;
					bcnt_nxt    = 3'h0;
				end
				else if (rx)
					state_nxt = S_HALT;
			S_DATA:
				if (rx)
				begin
					wb_we    = 1'b1;
					bcnt_nxt = bcnt_r + 3'h1;
					crc_nxt  = crc_upd;
					if (bcnt_r == 3'h7)
					begin
						tx_sh_nxt   = ~crc_upd;
						tx_last_nxt = 1'b0;
						ret_nxt     = S_RELEASE;
						state_nxt   = S_TX;
					end
				end
			S_RELEASE:
				if (rx)
				begin
					// Any value releases; refusals skip the programming time
					tx_last_nxt = 1'b1;
					ret_nxt     = S_HALT;
					if (blk_prot)
					begin
						tx_sh_nxt = {8'h00, CS_PROTECTED};
						state_nxt = S_TX;
					end
					else if (cnt_zero)
					begin
						tx_sh_nxt = {8'h00, CS_EXHAUSTED};
						state_nxt = S_TX;
					end
					else
					begin
						timer_nxt = timer_ld;
						state_nxt = S_PROG;
					end
				end
			S_PROG:
				if (!timer_end)
					timer_nxt = timer_r - 23'h000001;
				else
				begin
					tx_last_nxt = 1'b1;
					state_nxt   = S_TX;
					if (i_prog_fault)
					begin
						tx_sh_nxt = {8'h00, CS_FAULT};
						ret_nxt   = S_HALT;
					end
					else
					begin
						prog_we   = 1'b1;
						tx_sh_nxt = {8'h00, cnt_left, CS_OK_NIBBLE};
						ret_nxt   = blk_last ? S_HALT : S_DATA;
						blk_nxt   = blk_last ? blk_r : blk_r + 5'h01;
						crc_nxt   = CRC16_INIT;
						bcnt_nxt  = 3'h0;
					end
				end
			S_TX:
				if (i_tx_done)
				begin
					if (tx_last_r)
						state_nxt = ret_r;
					else
					begin
						tx_sh_nxt   = {8'h00, tx_sh_r[15:8]};
						tx_last_nxt = 1'b1;
					end
				end
			S_HALT: ;
		endcase
		if (i_bus_reset)
		begin
			state_nxt = S_IDLE;
			crc_nxt   = CRC16_INIT;
		end
	end

	// Control registers
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_r   <= S_IDLE;
			ret_r     <= S_IDLE;
			blk_r     <= 5'h00;
			bcnt_r    <= 3'h0;
			crc_r     <= CRC16_INIT;
			tx_sh_r   <= 16'h0000;
			tx_last_r <= 1'b0;
			timer_r   <= 23'h000000;
			o_busy    <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			ret_r     <= ret_nxt;
			blk_r     <= blk_nxt;
			bcnt_r    <= bcnt_nxt;
			crc_r     <= crc_nxt;
			tx_sh_r   <= tx_sh_nxt;
			tx_last_r <= tx_last_nxt;
			timer_r   <= timer_nxt;
			o_busy    <= state_nxt == S_PROG;
		end
	end

	// Byte emitter: one pulse per byte, then wait for the layer below
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_tx_byte <= '0;
			tx_wait_r <= 1'b0;
		end
		else
		begin
			o_tx_byte.valid <= state_r == S_TX && !tx_wait_r && !i_bus_reset;
			o_tx_byte.data  <= tx_sh_r[7:0];
			if (i_bus_reset || i_tx_done)
				tx_wait_r <= 1'b0;
			else if (state_r == S_TX)
				tx_wait_r <= 1'b1;
		end
	end

	// Protection and remaining counts; reset stands in for the stored state
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			prot_r <= '0;
			for (int i = 0; i < ADMIN_BYTES; i++)
				adm_r[i] <= {4'h0, MAX_WRITES};
		end
		else
		begin
			if (i_prot_req.valid && i_prot_req.block <= LAST_BLOCK)
				prot_r[i_prot_req.block] <= 1'b1;
			if (prog_we)
				adm_r[blk_r] <= {4'h0, cnt_left};
		end
	end

	// Write buffer and user array; no reset, as a real array has none
	always_ff @(posedge i_core_clk)
	begin
		if (wb_we)
			wbuf_r[bcnt_r] <= rd;
		if (prog_we)
			for (int i = 0; i < BLOCK_BYTES; i++)
				mem_r[{blk_r, 3'(i)}] <= wbuf_r[i];
		o_rd_data <= (i_rd_addr < 8'(USER_BYTES)) ? mem_r[i_rd_addr] : UNMAPPED_READ;
	end

	// Identifier CRC built serially after reset, family code first
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			id_cnt_r          <= 6'h00;
			crc8_r            <= CRC8_INIT;
			o_node_identifier <= 64'h0000_0000_0000_0000;
			o_id_ready        <= 1'b0;
		end
		else if (id_cnt_r != ID_DATA_LAST)
		begin
			crc8_r   <= bwe_crc8_bit(crc8_r, id_data[id_cnt_r]);
			id_cnt_r <= id_cnt_r + 6'h01;
		end
		else if (!o_id_ready)
		begin
			o_node_identifier <= {crc8_r, id_data};
			o_id_ready        <= 1'b1;
		end
	end

	// Helper: CRC of the whole identifier, which must come to zero
	logic [7:0] id_chk;
	always_comb
	begin
		id_chk = CRC8_INIT;
		for (int i = 0; i < 64; i++)
			id_chk = bwe_crc8_bit(id_chk, o_node_identifier[i]);
	end

	a_id_crc_zero: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		o_id_ready |-> id_chk == 8'h00)
		else $error("node identifier CRC does not check");

	a_prot_sticky: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		($past(prot_r) & ~prot_r) == '0)
		else $error("write protection was cleared");

	a_param_crc_inv: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_r == S_PARAM && rx && idx_ok && !i_bus_reset |=>
		tx_sh_r == ~bwe_crc16(bwe_crc16(CRC16_INIT, CMD_WRITE_BLOCK), $past(rd)) && state_r == S_TX)
		else $error("parameter confirmation CRC wrong");

	a_bad_param_halt: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_r == S_PARAM && rx && rd[BLK_IDX_MSB:0] == 5'h1f && !i_bus_reset |=> state_r == S_HALT)
		else $error("invalid block number accepted");

	a_data_crc_inv: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_r == S_DATA && rx && bcnt_r == 3'h7 && !i_bus_reset |=>
		tx_sh_r == ~bwe_crc16($past(crc_r), $past(rd)) && ret_r == S_RELEASE)
		else $error("data confirmation CRC wrong");

	a_data_crc_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_r == S_DATA && bcnt_r == 3'h0 |-> crc_r == CRC16_INIT)
		else $error("data CRC generator not cleared before a block");

	a_refuse_prot: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_r == S_RELEASE && rx && blk_prot && !i_bus_reset |=>
		tx_sh_r[7:0] == CS_PROTECTED && !o_busy ##1 o_tx_byte.valid)
		else $error("protected block not refused");

	a_prog_start: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_r == S_RELEASE && rx && !blk_prot && !cnt_zero && !i_bus_reset |=>
		o_busy && timer_r == timer_ld)
		else $error("programming did not start on release");

	a_status_ok: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state_r == S_PROG && timer_end && !i_prog_fault && !i_bus_reset |=>
		tx_sh_r[3:0] == CS_OK_NIBBLE && tx_sh_r[7:4] == $past(blk_cnt) - 4'h1)
		else $error("success status wrong");

	a_count_bound: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		prog_we |=> adm_r[$past(blk_r)][3:0] == $past(blk_cnt) - 4'h1 && $past(blk_cnt) <= MAX_WRITES)
		else $error("write count not decremented");

	a_next_block: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		prog_we && !blk_last && !i_bus_reset |=> blk_r == $past(blk_r) + 5'h01 && ret_r == S_DATA)
		else $error("write flow did not advance block");

endmodule : bwe_block_write_engine
`default_nettype wire

// [test/bwe_master_model.sv]
// Byte-level bus master model: takes each offered byte and acknowledges it after a delay
`timescale 1ns/1ps
`default_nettype none
module bwe_master_model
	import bwe_pkg::*;
(
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_resetn,
	// Byte offered by the device, and acknowledge delay in cycles
	input  wire bwe_byte_t  i_tx_byte,
	input  wire logic [3:0] i_delay,
	// Acknowledge, last byte taken and byte count
	output logic            o_tx_done,
	output logic [7:0]      o_got,
	output logic [15:0]     o_cnt
);
	logic       busy_r;
	logic [3:0] wait_r;

	// A slow delay mimics a bit layer still clocking the byte out
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			busy_r    <= 1'b0;
			wait_r    <= 4'h0;
			o_tx_done <= 1'b0;
			o_got     <= 8'h00;
			o_cnt     <= 16'h0000;
		end
		else
		begin
			o_tx_done <= 1'b0;
			if (i_tx_byte.valid)
			begin
				busy_r <= 1'b1;
				wait_r <= i_delay;
				o_got  <= i_tx_byte.data;
			end
			else if (busy_r && wait_r == 4'h0)
			begin
				busy_r    <= 1'b0;
				o_tx_done <= 1'b1;
				o_cnt     <= o_cnt + 16'h0001;
			end
			else if (busy_r)
				wait_r <= wait_r - 4'h1;
		end
	end
endmodule : bwe_master_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking testbench of the block write engine
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import bwe_pkg::*;
;
	localparam logic [7:0]  FAM = 8'h5c;            // Arbitrary value
	localparam logic [47:0] SER = 48'h1122_3344_5566; // Arbitrary value
	localparam int          PROG = 20;                // Short programming time keeps the run brief
	logic          clk, resetn, bus_rst, tx_done, fault, id_rdy, busy;
	bwe_byte_t     rx, tx;
	bwe_prot_req_t prot;
	logic [7:0]    rd_addr, rd_data, got, mem [256];
	logic [63:0]   node_id;
	logic [15:0]   mcnt;
	logic [3:0]    dly, cnt [31];
	logic          prot_m [31], wr [31];
	logic [31:0]   lfsr;
	int            err_total, checks;

	bwe_block_write_engine #(.P_PROG_CYCLES(PROG), .P_FAMILY_CODE(FAM), .P_SERIAL(SER)) dut (
		.i_core_clk(clk), .i_resetn(resetn), .i_rx_byte(rx), .i_bus_reset(bus_rst),
		.i_tx_done(tx_done), .o_tx_byte(tx), .i_prog_fault(fault), .i_prot_req(prot),
		.i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_node_identifier(node_id),
		.o_id_ready(id_rdy), .o_busy(busy));
	bwe_master_model mst (.i_core_clk(clk), .i_resetn(resetn), .i_tx_byte(tx), .i_delay(dly),
		.o_tx_done(tx_done), .o_got(got), .o_cnt(mcnt));

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [7:0] rnd();
		repeat (8) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction : rnd

	// Bitwise CRC models, shifted least significant bit first
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'ha001 : 16'h0000);
		return c;
	endfunction : crc16

	function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++)
			c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction : crc8

	task automatic results();
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string name);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic send(input logic [7:0] b);
		@(negedge clk) rx = {1'b1, b};
		@(negedge clk) rx = '0;
	endtask : send

	task automatic bus_reset();
		@(negedge clk) bus_rst = 1'b1;
		@(negedge clk) bus_rst = 1'b0;
	endtask : bus_reset

	// Waits for the next byte taken by the master, bounded
	task automatic recv(input logic [7:0] exp);
		logic [15:0] c0;
		c0 = mcnt;
		for (int n = 0; n < 400 && mcnt == c0; n++)
			@(negedge clk);
		if (mcnt == c0)
		begin
			err_total++;
			results();
		end
		else
			check(got, exp, "tx byte");
	endtask : recv

	task automatic silent();
		logic [15:0] c0;
		c0 = mcnt;
		repeat (40) @(negedge clk);
		check(mcnt, c0, "reply count");
	endtask : silent

	// Every new flow opens with a bus reset, which also ends a failed one
	task automatic start(input logic [7:0] p);
		logic [15:0] c;
		bus_reset();
		send(CMD_WRITE_BLOCK);
		send(p);
		c = crc16(crc16(16'h0000, 8'h55), p);
		recv(~c[7:0]);
		recv(~c[15:8]);
	endtask : start

	// One block: data, data CRC, release byte, status
	task automatic group(input logic [4:0] blk);
		logic [15:0] c;
		logic [7:0]  d [8];
		logic [7:0]  st;
		int          n;
		c = 16'h0000;
		for (int i = 0; i < 8; i++)
		begin
			d[i] = rnd();
			c = crc16(c, d[i]);
			send(d[i]);
		end
		recv(~c[7:0]);
		recv(~c[15:8]);
		if (prot_m[blk])
			st = CS_PROTECTED;
		else if (cnt[blk] == 4'h0)
			st = CS_EXHAUSTED;
		else if (fault)
			st = CS_FAULT;
		else
		begin
			cnt[blk] = cnt[blk] - 4'h1;
			st = {cnt[blk], 4'ha};
			wr[blk] = 1'b1;
			for (int i = 0; i < 8; i++)
				mem[blk * 8 + i] = d[i];
		end
		send(rnd());
		@(negedge clk);
		check(busy, st != CS_PROTECTED && st != CS_EXHAUSTED, "busy");
		// Busy was already high one cycle before this sample
		n = 1;
		while (busy && n < 64)
		begin
			n++;
			@(negedge clk);
		end
		if (n > 1)
			check(n, PROG, "programming time");
		recv(st);
	endtask : group

	initial
	begin
		logic [4:0] b;
		err_total = 0;
		checks = 0;
		lfsr = 32'h31ed;
		resetn = 1'b0;
		rx = '0;
		bus_rst = 1'b0;
		fault = 1'b0;
		prot = '0;
		rd_addr = 8'h00;
		dly = 4'h0;
		for (int i = 0; i < 31; i++)
		begin
			cnt[i] = 4'h8;
			prot_m[i] = 1'b0;
			wr[i] = 1'b0;
		end
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		// Identifier and its CRC
		repeat (60) @(negedge clk);
		check(id_rdy, 1'b1, "id ready");
		check(node_id, {crc8({8'h00, SER, FAM}, 56), SER, FAM}, "identifier");
		check(crc8(node_id, 64), 8'h00, "identifier residue");
		// Adjacent blocks up to the last one, upper parameter bits ignored, then halted
		start({3'b101, 5'h1d});
		group(5'h1d);
		group(5'h1e);
		send(8'h00);
		silent();
		// Invalid block number and a foreign command get no reply
		bus_reset();
		send(CMD_WRITE_BLOCK);
		send(8'h1f);
		silent();
		bus_reset();
		send(8'hf0);
		send(8'h00);
		silent();
		// Eight writes, then exhausted
		repeat (9)
		begin
			start(8'h02);
			group(5'h02);
		end
		// Protection refuses and survives a bus reset
		@(negedge clk) prot = {1'b1, 5'h05};
		@(negedge clk) prot = '0;
		prot_m[5] = 1'b1;
		repeat (2)
		begin
			start(8'h05);
			group(5'h05);
		end
		// Programming fault; that block's content is left unchecked
		fault = 1'b1;
		start(8'h09);
		group(5'h09);
		fault = 1'b0;
		// Random blocks with a prompt or slow master
		repeat (8)
		begin
			b = 5'(rnd() % 31);
			if (b == 5'h09)
				b = 5'h0a;
			dly = 4'(rnd());
			start({rnd() & 8'he0 | {3'b000, b}});
			group(b);
		end
		// User memory read back, unmapped bytes read as all ones
		for (int a = 0; a < 256; a++)
		begin
			rd_addr = a[7:0];
			@(negedge clk);
			if (a >= USER_BYTES)
				check(rd_data, UNMAPPED_READ, "unmapped read");
			else if (wr[a / 8])
				check(rd_data, mem[a], "user memory");
		end
		results();
	end
endmodule : tb_top
`default_nettype wire
